// ### src/ea_gen_defines.vh
`ifndef EA_GEN_DEFINES_VH
`define EA_GEN_DEFINES_VH
// addressing mode codes
`define MODE_IMPLIED 4'h0
`define MODE_ABS 4'h1
`define MODE_ZP 4'h2
`define MODE_ZP_X 4'h3
`define MODE_ZP_Y 4'h4
`define MODE_ABS_X 4'h5
`define MODE_ABS_Y 4'h6
`define MODE_REL 4'h7
`define MODE_IND_X 4'h8
`define MODE_IND_Y 4'h9
`define MODE_IND_JMP 4'hA
// page zero high byte
`define PAGE_ZERO 8'h00
`define PTR_STEP 8'h01
`define PTR_STEP16 16'h0001
`define SIGN_BIT 7
`endif

// ### src/ea_adder.v
`timescale 1ns/1ps
`default_nettype none
module ea_adder (
	// operands
	input wire [15:0] base,
	input wire [7:0] offset,
	input wire signed_offset,
	input wire wrap_page,
	// result
	output wire [15:0] sum
);
`include "ea_gen_defines.vh"
	wire [8:0] low_sum;
	wire carry;
	wire [7:0] high_adj;
	assign low_sum = {1'b0, base[7:0]} + {1'b0, offset};
	assign carry = low_sum[8];
	// high byte: carry, or carry minus one for negative offset
	assign high_adj = signed_offset ? (offset[`SIGN_BIT] ? (carry ? 8'h00 : 8'hFF) : {7'h00, carry}) : {7'h00, carry};
	assign sum = wrap_page ? {`PAGE_ZERO, low_sum[7:0]} : {base[15:8] + high_adj, low_sum[7:0]};
endmodule
`default_nettype wire

// ### src/effective_address_generator.v
// Overview of operation
// - absolute: first operand byte is low address, second is high, full space
// - zero page: one operand byte as low address, high byte forced zero
// - zero page indexed: low address is operand plus selected index
// - zero page indexed sum wraps in page zero, no carry upward
// - absolute indexed: index added to 16-bit base from operand bytes
// - implied: no operand address bytes fetched, location from opcode
// - relative: signed operand added to next-instruction program counter
// - pre-indexed indirect: operand plus first index, carry dropped, gives pointer
// - pre-indexed indirect: low byte at pointer, high at next, in page zero
// - post-indexed indirect: pointer low byte plus second index gives low address
// - post-indexed indirect: low-sum carry added to pointer high byte
// - indirect jump: read target bytes at pointer and next, load program counter
// - address lines are 12, 13 or 16 wide by variant
// - a valid address is driven every cycle, no qualifier needed
// - opcode-fetch indicator high only in the cycle after an idle cycle with no start, low in the fetch cycle after done
`timescale 1ns/1ps
`default_nettype none
module effective_address_generator #(
	parameter ADDR_WIDTH = 16
) (
	// clock and reset
	input wire ref_clk,
	input wire reset,
	// decoder request
	input wire start,
	input wire [3:0] mode,
	input wire [15:0] pc_next,
	input wire [7:0] index_x,
	input wire [7:0] index_y,
	// memory read data
	input wire [7:0] read_data,
	// memory side
	output reg [ADDR_WIDTH-1:0] address_lines,
	output reg opcode_fetch,
	output reg valid_memory_address_qualifier,
	// result
	output reg [15:0] effective_address,
	output reg [15:0] pc_load,
	output reg pc_load_valid,
	output reg done,
	output reg busy
);
`include "ea_gen_defines.vh"
	localparam S_OPCODE = 3'h0;
	localparam S_OP1 = 3'h1;
	localparam S_OP2 = 3'h2;
	localparam S_PTR_LO = 3'h3;
	localparam S_PTR_HI = 3'h4;
	localparam S_DONE = 3'h5;

	reg [2:0] state_reg, state_next;
	reg [3:0] mode_reg, mode_next;
	reg [15:0] fetch_pc_reg, fetch_pc_next;
	reg [7:0] op1_reg, op1_next;
	reg [7:0] op2_reg, op2_next;
	reg [7:0] lo_reg, lo_next;
	reg [15:0] addr_next;
	reg [15:0] ea_next;
	reg done_next, load_next, fetch_next;

	reg [15:0] add_base;
	reg [7:0] add_off;
	reg add_signed, add_wrap;
	wire [15:0] add_sum;

	function two_byte;
		input [3:0] m;
		begin
			two_byte = (m == `MODE_ABS) || (m == `MODE_ABS_X) || (m == `MODE_ABS_Y) || (m == `MODE_IND_JMP);
		end
	endfunction

	ea_adder u_adder (
		.base(add_base),
		.offset(add_off),
		.signed_offset(add_signed),
		.wrap_page(add_wrap),
		.sum(add_sum)
	);

	// adder operand selection
	always @* begin
		add_base = {op2_reg, op1_reg};
		add_off = 8'h00;
		add_signed = 1'b0;
		add_wrap = 1'b0;
		case (mode_reg)
			`MODE_ZP_X: begin
				add_base = {`PAGE_ZERO, op1_reg};
				add_off = index_x;
				add_wrap = 1'b1;
			end
			`MODE_ZP_Y: begin
				add_base = {`PAGE_ZERO, op1_reg};
				add_off = index_y;
				add_wrap = 1'b1;
			end
			`MODE_ABS_X: add_off = index_x;
			`MODE_ABS_Y: add_off = index_y;
			`MODE_REL: begin
				add_base = fetch_pc_reg;
				add_off = op1_reg;
				add_signed = 1'b1;
			end
			`MODE_IND_X: begin
				add_base = {`PAGE_ZERO, op1_reg};
				add_off = index_x;
				add_wrap = 1'b1;
			end
			`MODE_IND_Y: begin
				add_base = {read_data, lo_reg};
				add_off = index_y;
			end
			default: begin
				add_base = {op2_reg, op1_reg};
			end
		endcase
	end

	// sequencing
	always @* begin
		state_next = state_reg;
		mode_next = mode_reg;
		fetch_pc_next = fetch_pc_reg;
		op1_next = op1_reg;
		op2_next = op2_reg;
		lo_next = lo_reg;
		addr_next = fetch_pc_reg;
		ea_next = effective_address;
		done_next = 1'b0;
		load_next = 1'b0;
		fetch_next = 1'b0;
		case (state_reg)
			S_OPCODE: begin
				if (start) begin
					mode_next = mode;
					fetch_pc_next = pc_next;
					if (mode == `MODE_IMPLIED) begin
						ea_next = pc_next;
						state_next = S_DONE;
					end else begin
						addr_next = pc_next;
						state_next = S_OP1;
					end
				end else begin
					addr_next = pc_next;
					fetch_next = 1'b1;
				end
			end
			S_OP1: begin
				op1_next = read_data;
				fetch_pc_next = fetch_pc_reg + `PTR_STEP16;
				addr_next = fetch_pc_reg + `PTR_STEP16;
				if (two_byte(mode_reg)) begin
					state_next = S_OP2;
				end else if (mode_reg == `MODE_IND_X || mode_reg == `MODE_IND_Y) begin
					state_next = S_PTR_LO;
				end else begin
					state_next = S_DONE;
				end
			end
			S_OP2: begin
				op2_next = read_data;
				fetch_pc_next = fetch_pc_reg + `PTR_STEP16;
				addr_next = fetch_pc_reg + `PTR_STEP16;
				state_next = (mode_reg == `MODE_IND_JMP) ? S_PTR_LO : S_DONE;
			end
			S_PTR_LO: begin
				if (mode_reg == `MODE_IND_X) begin
					addr_next = add_sum;
				end else if (mode_reg == `MODE_IND_Y) begin
					addr_next = {`PAGE_ZERO, op1_reg};
				end else begin
					addr_next = {op2_reg, op1_reg};
				end
				state_next = S_PTR_HI;
			end
			S_PTR_HI: begin
				lo_next = read_data;
				if (mode_reg == `MODE_IND_JMP) begin
					addr_next = {op2_reg, op1_reg} + `PTR_STEP16;
				end else begin
					addr_next = {`PAGE_ZERO, address_lines[7:0] + `PTR_STEP};
				end
				state_next = S_DONE;
			end
			default: begin
				case (mode_reg)
					`MODE_ABS: ea_next = {op2_reg, op1_reg};
					`MODE_ZP: ea_next = {`PAGE_ZERO, op1_reg};
					`MODE_IND_X: ea_next = {read_data, lo_reg};
					`MODE_IND_JMP: begin
						ea_next = {read_data, lo_reg};
						load_next = 1'b1;
					end
					`MODE_IMPLIED: ea_next = effective_address;
					default: ea_next = add_sum;
				endcase
				if (mode_reg == `MODE_REL) begin
					load_next = 1'b1;
				end
				done_next = 1'b1;
				addr_next = fetch_pc_reg;
				state_next = S_OPCODE;
			end
		endcase
	end

	always @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= S_OPCODE;
			mode_reg <= `MODE_IMPLIED;
			fetch_pc_reg <= 16'h0000;
			op1_reg <= 8'h00;
			op2_reg <= 8'h00;
			lo_reg <= 8'h00;
			address_lines <= {ADDR_WIDTH{1'b0}};
			opcode_fetch <= 1'b0;
			valid_memory_address_qualifier <= 1'b1;
			effective_address <= 16'h0000;
			pc_load <= 16'h0000;
			pc_load_valid <= 1'b0;
			done <= 1'b0;
			busy <= 1'b0;
		end else begin
			state_reg <= state_next;
			mode_reg <= mode_next;
			fetch_pc_reg <= fetch_pc_next;
			op1_reg <= op1_next;
			op2_reg <= op2_next;
			lo_reg <= lo_next;
			address_lines <= addr_next[ADDR_WIDTH-1:0];
			opcode_fetch <= fetch_next;
			valid_memory_address_qualifier <= 1'b1;
			effective_address <= ea_next;
			pc_load <= ea_next;
			pc_load_valid <= load_next;
			done <= done_next;
			busy <= (state_next != S_OPCODE);
		end
	end
endmodule
`default_nettype wire

// ### bench/ea_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ea_mem_model (
	// bus
	input wire logic ref_clk,
	input wire logic [15:0] address_lines,
	output var logic [7:0] read_data
);
	logic [7:0] mem [0:65535];
	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		read_data = 8'h00;
	end
	// data for the address launched at the last rising edge, ready for the next one
	always @(negedge ref_clk) read_data <= mem[address_lines];
endmodule
`default_nettype wire

// ### bench/ea_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "ea_gen_defines.vh"
module ea_checker #(
	parameter ADDR_WIDTH = 16
) (
	// clock, reset, request
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic start,
	input wire logic [3:0] mode,
	input wire logic [15:0] pc_next,
	// results
	input wire logic [ADDR_WIDTH-1:0] address_lines,
	input wire logic opcode_fetch,
	input wire logic valid_memory_address_qualifier,
	input wire logic [15:0] effective_address,
	input wire logic [15:0] pc_load,
	input wire logic pc_load_valid,
	input wire logic done,
	input wire logic busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire logic take = start && !busy;
	wire logic [ADDR_WIDTH-1:0] pc_low = pc_next[ADDR_WIDTH-1:0];
	a_qual_high: assert property (valid_memory_address_qualifier) else $error("qual low");
	a_fetch_off: assert property (take |=> busy && !opcode_fetch) else $error("fetch flag");
	a_fetch_idle: assert property (!busy && !start |=> opcode_fetch) else $error("fetch idle");
	a_addr_idle: assert property (!busy && !start |=> address_lines == $past(pc_low))
		else $error("idle address");
	a_impl_result: assert property (take && mode == `MODE_IMPLIED
		|-> ##2 done && effective_address == $past(pc_next, 2)) else $error("implied");
	a_zp_page: assert property (take && mode == `MODE_ZP
		|-> ##3 done && effective_address[15:8] == 8'h00) else $error("zp high");
	a_zpi_wrap: assert property (take && (mode == `MODE_ZP_X || mode == `MODE_ZP_Y)
		|-> ##3 done && effective_address[15:8] == 8'h00) else $error("zp wrap");
	a_rel_load: assert property (take && mode == `MODE_REL |-> ##3 done && pc_load_valid) else $error("rel");
	a_abs_time: assert property (take && (mode == `MODE_ABS || mode == `MODE_ABS_X || mode == `MODE_ABS_Y)
		|-> ##4 done) else $error("abs");
	a_ind_time: assert property (take && (mode == `MODE_IND_X || mode == `MODE_IND_Y)
		|-> ##5 done) else $error("ind");
	a_jmp_load: assert property (take && mode == `MODE_IND_JMP
		|-> ##6 done && pc_load_valid && pc_load == effective_address) else $error("jmp");
endmodule
bind effective_address_generator ea_checker #(.ADDR_WIDTH(ADDR_WIDTH)) ea_checker_inst (.ref_clk(ref_clk),
	.reset(reset), .start(start), .mode(mode), .pc_next(pc_next), .address_lines(address_lines),
	.opcode_fetch(opcode_fetch), .pc_load(pc_load),
	.valid_memory_address_qualifier(valid_memory_address_qualifier), .effective_address(effective_address),
	.pc_load_valid(pc_load_valid), .done(done), .busy(busy));
`default_nettype wire

// ### bench/effective_address_generator_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ea_gen_defines.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; $display("FAIL %0t got %h want %h", $time, a, b); end end
module effective_address_generator_tb;
	logic ref_clk = 1'b0, reset = 1'b1, start = 1'b0, opcode_fetch, qual, pc_load_valid, done, busy;
	logic [3:0] mode = 4'h0;
	logic [15:0] pc_next = 16'h0000, effective_address, pc_load, address_lines;
	logic [7:0] index_x = 8'h00, index_y = 8'h00, read_data;
	logic [11:0] addr_narrow;
	int mismatches = 0, tests_run = 0;
	always #20 ref_clk = ~ref_clk;
	effective_address_generator effective_address_generator_inst (.ref_clk(ref_clk), .reset(reset), .start(start),
		.mode(mode), .pc_next(pc_next), .index_x(index_x), .index_y(index_y), .read_data(read_data),
		.address_lines(address_lines), .opcode_fetch(opcode_fetch), .valid_memory_address_qualifier(qual),
		.effective_address(effective_address), .pc_load(pc_load), .pc_load_valid(pc_load_valid), .done(done), .busy(busy));
	effective_address_generator #(.ADDR_WIDTH(12)) effective_address_generator_narrow_inst (.ref_clk(ref_clk),
		.reset(reset), .start(start), .mode(mode), .pc_next(pc_next), .index_x(index_x), .index_y(index_y),
		.read_data(read_data), .address_lines(addr_narrow), .opcode_fetch(), .valid_memory_address_qualifier(),
		.effective_address(), .pc_load(), .pc_load_valid(), .done(), .busy());
	ea_mem_model ea_mem_model_inst (.ref_clk(ref_clk), .address_lines(address_lines), .read_data(read_data));
	task complete_run;
		if (mismatches == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task put(input logic [15:0] a, input logic [7:0] d);
		ea_mem_model_inst.mem[a] = d;
	endtask
	task go(input logic [3:0] m, input logic [15:0] pc);
		int n;
		@(negedge ref_clk);
		mode = m;
		pc_next = pc;
		start = 1'b1;
		@(negedge ref_clk);
		start = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 20) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 20) begin
			mismatches++;
			$display("FAIL %0t no done", $time);
		end
	endtask
	task t_width;
		@(negedge ref_clk);
		pc_next = 16'hABCD;
		@(negedge ref_clk);
		`CHK(address_lines, 16'hABCD)
		`CHK(addr_narrow, 12'hBCD)
		`CHK(opcode_fetch, 1'b1)
		`CHK(qual, 1'b1)
	endtask
	task t_abs;
		put(16'h1200, 8'h34);
		put(16'h1201, 8'h12);
		go(`MODE_ABS, 16'h1200);
		`CHK(effective_address, 16'h1234)
		go(`MODE_ZP, 16'h1200);
		`CHK(effective_address, 16'h0034)
	endtask
	task t_index;
		index_x = 8'hF0;
		index_y = 8'hE0;
		put(16'h1200, 8'h20);
		go(`MODE_ZP_X, 16'h1200);
		`CHK(effective_address, 16'h0010)
		go(`MODE_ZP_Y, 16'h1200);
		`CHK(effective_address, 16'h0000)
		put(16'h1200, 8'hF0);
		go(`MODE_ABS_X, 16'h1200);
		`CHK(effective_address, 16'h13E0)
		go(`MODE_ABS_Y, 16'h1200);
		`CHK(effective_address, 16'h13D0)
		go(`MODE_IMPLIED, 16'h2345);
		`CHK(effective_address, 16'h2345)
	endtask
	task t_rel;
		put(16'h1000, 8'h80);
		go(`MODE_REL, 16'h1000);
		`CHK(pc_load, 16'h0F81)
		put(16'h1000, 8'h7F);
		go(`MODE_REL, 16'h1000);
		`CHK(pc_load, 16'h1080)
	endtask
	task t_ind;
		index_x = 8'h20;
		index_y = 8'h20;
		put(16'h0010, 8'hCD);
		put(16'h0011, 8'hAB);
		go(`MODE_IND_X, 16'h1200);
		`CHK(effective_address, 16'hABCD)
		put(16'h1200, 8'h40);
		put(16'h0040, 8'hF0);
		put(16'h0041, 8'h12);
		go(`MODE_IND_Y, 16'h1200);
		`CHK(effective_address, 16'h1310)
		put(16'h1200, 8'h00);
		put(16'h1201, 8'h30);
		put(16'h3000, 8'h78);
		put(16'h3001, 8'h56);
		go(`MODE_IND_JMP, 16'h1200);
		`CHK(pc_load, 16'h5678)
	endtask
	initial begin
		repeat (10) @(negedge ref_clk);
		reset = 1'b0;
		t_abs;
		t_index;
		t_rel;
		t_ind;
		t_width;
		complete_run;
	end
	initial begin
		#20000;
		mismatches++;
		$display("FAIL %0t watchdog", $time);
		complete_run;
	end
endmodule
`default_nettype wire
